// ### design/csi_pkg.sv
package csi_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_CTRL3 = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_TXSLOT = 8'h10;
    localparam logic [7:0] OFF_RXSLOT = 8'h14;
    localparam logic [3:0] AREA_TXBUF = 4'h2;
    localparam logic [3:0] AREA_RXBUF = 4'h3;

    // interface_control_one field positions
    localparam int C1_EN = 15;
    localparam int C1_CLKDIR = 10;
    localparam int C1_EDGE = 9;
    localparam int C1_FSDIR = 8;
    localparam int C1_UNFM = 7;
    localparam int C1_IDLE = 6;

    // second control register field positions
    localparam int C2_BLEN_LO = 10;
    localparam int C2_FRAME_LO = 5;
    localparam int C2_WS_LO = 0;

    // status field positions
    localparam int ST_SLOT_LO = 8;
    localparam int ST_ROV = 3;
    localparam int ST_RFUL = 2;
    localparam int ST_TUNF = 1;
    localparam int ST_TMPTY = 0;

    // writable bits and values after reset
    localparam logic [15:0] CTRL1_MASK = 16'h87c3;
    localparam logic [15:0] CTRL2_MASK = 16'h0def;
    localparam logic [15:0] CTRL3_MASK = 16'h0fff;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] SLOT_RST = 16'h0000;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // framing counts
    localparam int WORD_BITS = 16;
    localparam int BUF_WORDS = 4;
    localparam logic [4:0] AC_LAST_BIT = 5'h0f;
    localparam logic [4:0] AC20_LAST_BIT = 5'h13;
    localparam logic [4:0] AC_TAG_LAST = 5'h0e;
    localparam logic [3:0] AC_LAST_SLOT = 4'hc;
    localparam int RXQ_DEPTH = 2;

    // frame_sync_mode_select encodings
    typedef enum logic [1:0] {
        FS_MULTI = 2'b00,
        FS_I2S = 2'b01,
        FS_AC16 = 2'b10,
        FS_AC20 = 2'b11
    } fs_mode_e;

endpackage

// ### design/csi_rx_queue.sv
`timescale 1ns/1ps
module csi_rx_queue
    import csi_pkg::*;
#(
    parameter int WIDTH = 18,
    parameter int DEPTH = RXQ_DEPTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH]; // word storage
    logic [PW-1:0] wp; // write index
    logic [PW-1:0] rp; // read index
    logic [PW:0] cnt; // words held
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt != (PW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk) begin
        if (!rstn || flush) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= (wp == PW'(DEPTH - 1)) ? '0 : PW'(wp + 1'b1);
            end
            if (pop) begin
                rp <= (rp == PW'(DEPTH - 1)) ? '0 : PW'(rp + 1'b1);
            end
            cnt <= (PW+1)'(cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
        end
    end
endmodule

// ### design/converter_serial_interface.sv
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
// Function
// - word length programmable up to 16 bits
// - up to 16 slots, frame at most 256 bits
// - four samples buffered each direction
// - multi-channel, inter-IC sound and AC-link framing
// - enabled block owns three pin directions: bit clock, data out, frame sync
// - clock direction selects bit clock out or in
// - data out is output only when enabled
// - idle slots float or drive low data out
// - data in is input only, never driven
// - frame sync aligns both data pins, direction selectable
// - shadow copies keep bus and shifter apart
// - buffer words are left-justified
// - short received words zero-filled in low bits
// - 16-bit shift register, msb first
// - idle mode one floats, zero drives zeros
// - two-bit field selects the framing mode
// - edge select picks change and sample edges
module converter_serial_interface
    import csi_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic clock_pin_in,
    output logic clock_pin_out,
    output logic clock_pin_oe,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic serial_in_pin,
    input wire logic frame_sync_pin_in,
    output logic frame_sync_pin_out,
    output logic frame_sync_pin_oe
);
    // control and status storage
    logic [15:0] ctrl1; // interface_control_one
    logic [15:0] ctrl2; // buffer length, frame length, word size
    logic [15:0] ctrl3; // bit clock divider
    logic [15:0] tx_slot_en; // transmit slot enables
    logic [15:0] rx_slot_en; // receive slot enables
    logic [15:0] tx_buf [BUF_WORDS]; // software transmit words
    logic [15:0] rx_buf [BUF_WORDS]; // software receive words
    logic [15:0] tx_shadow [BUF_WORDS]; // words the shifter reads
    logic [15:0] rx_shadow [BUF_WORDS]; // words the shifter fills
    logic rov, rful, tunf, tmpty; // status flags

    // control fields
    wire en = ctrl1[C1_EN];
    wire clk_in_mode = ctrl1[C1_CLKDIR];
    wire edge_sel = ctrl1[C1_EDGE];
    wire fs_in_mode = ctrl1[C1_FSDIR];
    wire unfm = ctrl1[C1_UNFM];
    wire idle_float = ctrl1[C1_IDLE];
    wire fs_mode_e mode = fs_mode_e'(ctrl1[1:0]);
    wire [1:0] blen = ctrl2[C2_BLEN_LO +: 2];
    wire [3:0] frame_last = ctrl2[C2_FRAME_LO +: 4];
    wire [3:0] ws = ctrl2[C2_WS_LO +: 4];
    wire ac = mode[1];

    // bus phase registers
    logic wr_pend, rd_pend;
    logic [7:0] wr_addr, rd_addr;

    // link state
    logic [2:0] sync1, sync2; // pin synchronisers
    logic [11:0] div_cnt; // bit clock divider count
    logic sck_gen; // generated bit clock
    logic sck_prev; // last seen bit clock level
    logic fs_prev; // frame sync at last sample edge
    logic start_pend; // frame start seen, apply at change edge
    logic [4:0] bit_cnt; // bit within slot
    logic [3:0] slot; // current slot
    logic [1:0] idx; // shared buffer index
    logic [15:0] tx_sh, rx_sh; // serial shift registers
    logic fs_out_q; // driven frame sync level

    // buffer area test, used for both directions
    function automatic logic in_area(input logic [7:0] a, input logic [3:0] area);
        return a[7:4] == area;
    endfunction

    // last bit index of a slot for the current framing
    function automatic logic [4:0] last_bit_of(input logic [3:0] s);
        if (mode == FS_AC20 && s != 4'h0) begin
            return AC20_LAST_BIT;
        end else if (ac) begin
            return AC_LAST_BIT;
        end
        return {1'b0, ws};
    endfunction

    // bus address phase decode
    wire addr_ph = hsel && htrans[1] && hready;
    wire rx_read = rd_pend && in_area(rd_addr, AREA_RXBUF);
    wire tx_write = wr_pend && in_area(wr_addr, AREA_TXBUF);
    wire stat_write = wr_pend && (wr_addr == OFF_STAT);

    // link edges; pin inputs are only read after two flops
    wire sck_lvl = clk_in_mode ? sync2[0] : sck_gen;
    wire rise = sck_lvl && !sck_prev;
    wire fall = !sck_lvl && sck_prev;
    wire sample_edge = en && (edge_sel ? rise : fall);
    wire change_edge = en && (edge_sel ? fall : rise);
    wire din = sync2[1];
    wire fs_lvl = fs_in_mode ? sync2[2] : fs_out_q;
    wire fs_seen = (mode == FS_I2S) ? (fs_prev && !fs_lvl) : (!fs_prev && fs_lvl);

    // position bookkeeping
    wire [3:0] last_slot = ac ? AC_LAST_SLOT : frame_last;
    wire end_slot = (bit_cnt == last_bit_of(slot));
    wire end_frame = end_slot && (slot == last_slot);
    wire [4:0] nbit = (start_pend || end_slot) ? 5'h00 : 5'(bit_cnt + 1'b1);
    wire [3:0] nslot = (start_pend || end_frame) ? 4'h0 : (end_slot ? 4'(slot + 1'b1) : slot);
    wire n_end_slot = (nbit == last_bit_of(nslot));
    wire n_end_frame = n_end_slot && (nslot == last_slot);

    // transmit path
    wire tx_active = tx_slot_en[nslot] && !nbit[4];
    wire [15:0] next_tx_sh = (nbit == 5'h00) ? tx_shadow[idx] : {tx_sh[14:0], 1'b0};

    // receive path; bits past 16 in wide slots are dropped
    wire [15:0] next_rx_sh = bit_cnt[4] ? rx_sh : {rx_sh[14:0], din};
    wire [3:0] rx_msb = ac ? 4'hf : ws;
    wire [15:0] rx_word = next_rx_sh << (4'hf - rx_msb);
    wire slot_done = sample_edge && end_slot;
    wire buf_step = slot_done && (tx_slot_en[slot] || rx_slot_en[slot]);
    wire buf_wrap = buf_step && (idx == blen);

    // frame sync to drive for the next bit
    logic next_fs;
    always_comb begin
        unique case (mode)
            FS_MULTI: next_fs = n_end_frame;
            FS_I2S: next_fs = nslot[0] ^ n_end_slot;
            default: next_fs = n_end_frame || (nslot == 4'h0 && nbit <= AC_TAG_LAST);
        endcase
    end

    // receive queue between shifter and receive shadow
    logic q_in_ready, q_out_valid;
    logic [17:0] q_out;
    wire q_push = slot_done && rx_slot_en[slot];
    wire q_pop = q_out_valid && !rx_read; // stall while software reads receive words
    wire [1:0] d_idx = q_out[17:16];
    wire d_last = q_pop && (d_idx == blen);

    csi_rx_queue #(.WIDTH(18), .DEPTH(RXQ_DEPTH)) u_rxq (
        .clk(clk),
        .rstn(rstn),
        .flush(!en),
        .in_valid(q_push),
        .in_ready(q_in_ready),
        .in_data({idx, rx_word}),
        .out_valid(q_out_valid),
        .out_ready(!rx_read),
        .out_data(q_out)
    );

    // register read selection
    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        if (in_area(rd_addr, AREA_TXBUF)) begin
            rd_val = tx_buf[rd_addr[3:2]];
        end else if (in_area(rd_addr, AREA_RXBUF)) begin
            rd_val = rx_buf[rd_addr[3:2]];
        end else begin
            case (rd_addr)
                OFF_CTRL1: rd_val = ctrl1;
                OFF_CTRL2: rd_val = ctrl2;
                OFF_CTRL3: rd_val = ctrl3;
                OFF_STAT: rd_val = {4'h0, slot, 4'h0, rov, rful, tunf, tmpty};
                OFF_TXSLOT: rd_val = tx_slot_en;
                OFF_RXSLOT: rd_val = rx_slot_en;
                default: rd_val = 16'h0000;
            endcase
        end
    end

    // bus phases: writes land the cycle after the address, reads wait one cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_ph && hwrite;
            rd_pend <= addr_ph && !hwrite;
            wr_addr <= addr_ph ? haddr[7:0] : wr_addr;
            rd_addr <= (addr_ph && !hwrite) ? haddr[7:0] : rd_addr;
            hreadyout <= !(addr_ph && !hwrite);
            hrdata <= rd_pend ? {16'h0000, rd_val} : hrdata;
        end
    end

    // control registers written by software
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl1 <= CTRL_RST;
            ctrl2 <= CTRL_RST;
            ctrl3 <= CTRL_RST;
            tx_slot_en <= SLOT_RST;
            rx_slot_en <= SLOT_RST;
        end else if (wr_pend) begin
            if (wr_addr == OFF_CTRL1) ctrl1 <= hwdata[15:0] & CTRL1_MASK;
            if (wr_addr == OFF_CTRL2) ctrl2 <= hwdata[15:0] & CTRL2_MASK;
            if (wr_addr == OFF_CTRL3) ctrl3 <= hwdata[15:0] & CTRL3_MASK;
            if (wr_addr == OFF_TXSLOT) tx_slot_en <= hwdata[15:0];
            if (wr_addr == OFF_RXSLOT) rx_slot_en <= hwdata[15:0];
        end
    end

    // buffer words and their shadows, one per index
    generate
        for (genvar i = 0; i < BUF_WORDS; i++) begin : g_buf
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    tx_buf[i] <= WORD_RST;
                    tx_shadow[i] <= WORD_RST;
                    rx_shadow[i] <= WORD_RST;
                    rx_buf[i] <= WORD_RST;
                end else begin
                    if (tx_write && wr_addr[3:2] == 2'(i)) tx_buf[i] <= hwdata[15:0];
                    // underflow repeats last words or sends zeros
                    if (buf_wrap) tx_shadow[i] <= (tmpty && !unfm) ? WORD_RST : tx_buf[i];
                    if (q_pop && d_idx == 2'(i)) rx_shadow[i] <= q_out[15:0];
                    if (d_last) rx_buf[i] <= (d_idx == 2'(i)) ? q_out[15:0] : rx_shadow[i];
                end
            end
        end
    endgenerate

    // status flags; a hardware set wins over a software clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rov <= 1'b0;
            rful <= 1'b0;
            tunf <= 1'b0;
            tmpty <= 1'b0;
        end else begin
            rov <= (q_push && !q_in_ready) || (d_last && rful) || (rov && !(stat_write && hwdata[ST_ROV]));
            rful <= d_last || (rful && !rx_read);
            tunf <= (buf_wrap && tmpty) || (tunf && !(stat_write && hwdata[ST_TUNF]));
            tmpty <= buf_wrap || (tmpty && !tx_write);
        end
    end

    // pin synchronisers: frame sync, data in, bit clock
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {frame_sync_pin_in, serial_in_pin, clock_pin_in};
            sync2 <= sync1;
        end
    end

    // bit clock generation, divider cleared while disabled or while the bit clock is an input
    always_ff @(posedge clk) begin
        if (!rstn || !en || clk_in_mode) begin
            div_cnt <= 12'h000;
            sck_gen <= 1'b0;
        end else if (div_cnt == ctrl3[11:0]) begin
            div_cnt <= 12'h000;
            sck_gen <= !sck_gen;
        end else begin
            div_cnt <= 12'(div_cnt + 1'b1);
        end
    end

    // frame position counters
    always_ff @(posedge clk) begin
        if (!rstn || !en) begin
            sck_prev <= 1'b0;
            fs_prev <= 1'b0;
            start_pend <= 1'b0;
            bit_cnt <= 5'h00;
            slot <= 4'h0;
            idx <= 2'h0;
        end else begin
            sck_prev <= sck_lvl;
            if (sample_edge) fs_prev <= fs_lvl;
            // a received frame sync restarts the frame at the next bit
            if (sample_edge && fs_in_mode && fs_seen) start_pend <= 1'b1;
            else if (change_edge) start_pend <= 1'b0;
            if (change_edge) begin
                bit_cnt <= nbit;
                slot <= nslot;
            end
            if (buf_step) idx <= buf_wrap ? 2'h0 : 2'(idx + 1'b1);
        end
    end

    // shift registers, receive on sample edge, transmit on change edge
    always_ff @(posedge clk) begin
        if (!rstn || !en) begin
            tx_sh <= 16'h0000;
            rx_sh <= 16'h0000;
        end else begin
            if (sample_edge) rx_sh <= next_rx_sh;
            if (change_edge) tx_sh <= next_tx_sh;
        end
    end

    // pin drivers; everything released while disabled
    always_ff @(posedge clk) begin
        if (!rstn || !en) begin
            clock_pin_out <= 1'b0;
            clock_pin_oe <= 1'b0;
            serial_out_pin <= 1'b0;
            serial_out_oe <= 1'b0;
            frame_sync_pin_out <= 1'b0;
            frame_sync_pin_oe <= 1'b0;
            fs_out_q <= 1'b0;
        end else begin
            clock_pin_out <= sck_gen;
            clock_pin_oe <= !clk_in_mode;
            frame_sync_pin_oe <= !fs_in_mode;
            if (change_edge) begin
                fs_out_q <= next_fs;
                frame_sync_pin_out <= next_fs;
                serial_out_pin <= tx_active && next_tx_sh[15];
                serial_out_oe <= tx_active || !idle_float;
            end
        end
    end
endmodule

// ### test/csi_monitor.sv
`timescale 1ns/1ps
module csi_monitor
    import csi_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic clock_pin_out,
    input wire logic clock_pin_oe,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    input wire logic frame_sync_pin_out,
    input wire logic frame_sync_pin_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // read or write accepted on the bus
    sequence take_rd_s; hsel && htrans[1] && hready && !hwrite; endsequence
    sequence take_wr_s; hsel && htrans[1] && hready && hwrite; endsequence
    // exactly one wait state
    sequence wait_one_s; !hreadyout ##1 hreadyout; endsequence
    // bit clock moved in this or the previous cycle
    sequence bit_edge_s; $changed(clock_pin_out) || $past(clock_pin_out) != $past(clock_pin_out, 2); endsequence
    okay_resp_a: assert property (hresp == 1'b0) else $error("bus response not okay");
    read_wait_a: assert property (take_rd_s |=> wait_one_s) else $error("read wait wrong");
    write_nowait_a: assert property (take_wr_s |=> hreadyout) else $error("write stalled");
    rdata_hold_a: assert property ($changed(hrdata) |-> hreadyout && !$past(hreadyout))
        else $error("read data moved");
    rdata_upper_a: assert property (hrdata[31:16] == 16'h0000) else $error("read data upper half");
    reset_quiet_a: assert property (disable iff (1'b0) !rstn |=>
        !clock_pin_oe && !serial_out_oe && !frame_sync_pin_oe) else $error("pin driven in reset");
    data_edge_a: assert property ($changed(serial_out_pin) && serial_out_oe && $past(serial_out_oe)
        && clock_pin_oe && $past(clock_pin_oe) |-> bit_edge_s) else $error("data off bit edge");
    sync_edge_a: assert property ($changed(frame_sync_pin_out) && frame_sync_pin_oe
        && $past(frame_sync_pin_oe) && clock_pin_oe |-> bit_edge_s) else $error("sync off bit edge");
endmodule
bind converter_serial_interface csi_monitor u_mon (.clk, .rstn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .clock_pin_out, .clock_pin_oe, .serial_out_pin, .serial_out_oe,
    .frame_sync_pin_out, .frame_sync_pin_oe);

// ### test/csi_codec_model.sv
`timescale 1ns/1ps
module csi_codec_model
    import csi_pkg::*;
(
    input wire logic ext,
    input wire logic bclk,
    input wire logic fs,
    input wire logic sdo,
    input wire logic [3:0] word,
    output logic clk_drv,
    output logic fs_drv,
    output logic sdi,
    output logic [3:0] got,
    output int frames
);
    logic [2:0] cnt = 3'h4; // bit of frame, 4 means idle
    logic [1:0] fcnt = 2'h0; // own frame position
    logic [3:0] sh = 4'h0; // capture shifter
    // codec clock runs only while the codec owns it
    initial begin
        clk_drv = 1'b0;
        fs_drv = 1'b0;
        sdi = 1'b0;
        got = 4'h0;
        frames = 0;
        forever #32 clk_drv = ext ? ~clk_drv : clk_drv;
    end
    // change edge: next bit, own sync high on last bit
    always @(negedge bclk) begin
        sdi <= (cnt < 3'h4) ? word[3 - cnt] : ~sdi;
        fcnt <= fcnt + 2'h1;
        fs_drv <= ext && fcnt == 2'h2;
    end
    // sample edge: msb first, restart after sync
    always @(posedge bclk) begin
        if (cnt < 3'h4) sh[3 - cnt] <= sdo;
        if (cnt == 3'h3) begin
            got <= {sh[3:1], sdo};
            frames <= frames + 1;
        end
        cnt <= fs ? 3'h0 : (cnt == 3'h4 ? cnt : cnt + 3'h1);
    end
endmodule

// ### test/converter_serial_interface_tb.sv
`timescale 1ns/1ps
module converter_serial_interface_tb
    import csi_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext = 1'b0, sdo_last = 1'b0, inv = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [3:0] word = 4'h0, got;
    logic hreadyout, hresp, clock_pin_out, clock_pin_oe, serial_out_pin, serial_out_oe;
    logic frame_sync_pin_out, frame_sync_pin_oe, clk_drv, fs_drv, sdi;
    int frames, n_fail = 0, total_checks = 0, cyc = 0;
    // pin levels from both parties; a floated data line keeps changing
    wire bclk = clock_pin_oe ? clock_pin_out : clk_drv;
    wire fs = frame_sync_pin_oe ? frame_sync_pin_out : fs_drv;
    wire sdo = (serial_out_oe === 1'b1) ? serial_out_pin : ~sdo_last;
    converter_serial_interface u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .clock_pin_in(bclk), .clock_pin_out(clock_pin_out),
        .clock_pin_oe(clock_pin_oe), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .serial_in_pin(sdi), .frame_sync_pin_in(fs), .frame_sync_pin_out(frame_sync_pin_out),
        .frame_sync_pin_oe(frame_sync_pin_oe));
    // codec sees the bit clock inverted when data change on its rising edge
    csi_codec_model u_codec (.ext(ext), .bclk(bclk ^ inv), .fs(fs), .sdo(sdo), .word(word), .clk_drv(clk_drv),
        .fs_drv(fs_drv), .sdi(sdi), .got(got), .frames(frames));
    initial begin
        forever #2 clk = ~clk;
    end
    // line memory and hang limit
    always @(posedge clk) begin
        sdo_last <= sdo;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            print_verdict;
        end
    end
    task print_verdict;
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one single bus transfer, waits on ready
    task bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsel <= 1'b1;
        htrans <= 2'b10;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 16'h0);
        chk(what, rd, exp);
    endtask
    task automatic regs_check;
        logic [7:0] offs [6] = '{OFF_CTRL1, OFF_CTRL2, OFF_CTRL3, OFF_STAT, OFF_TXSLOT, 8'h20};
        foreach (offs[i]) rchk(offs[i], 32'h0, "reset value");
        bus(1'b1, 8'h18, 16'hffff);
        rchk(8'h18, 32'h0, "unmapped");
        bus(1'b1, OFF_CTRL1, 16'h7fff);
        rchk(OFF_CTRL1, {16'h0, CTRL1_MASK & 16'h7fff}, "control one");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, OFF_CTRL1, 16'(m));
            rchk(OFF_CTRL1, 32'(m), "framing mode");
        end
        bus(1'b1, OFF_CTRL2, 16'hffff);
        rchk(OFF_CTRL2, {16'h0, CTRL2_MASK}, "control two");
        bus(1'b1, OFF_CTRL1, 16'h0);
        chk("pin enables", {clock_pin_oe, serial_out_oe, frame_sync_pin_oe}, 32'h0);
    endtask
    // one slot of 4-bit words each way, device or codec as clock master
    task run_link(input logic [15:0] c1, input logic [3:0] tx, input logic [3:0] rx_in);
        int s;
        word <= rx_in;
        ext <= c1[10];
        inv <= ~c1[9];
        bus(1'b1, OFF_CTRL2, 16'h0003);
        bus(1'b1, OFF_CTRL3, 16'h0007);
        bus(1'b1, OFF_TXSLOT, 16'h0001);
        bus(1'b1, OFF_RXSLOT, 16'h0001);
        bus(1'b1, {AREA_TXBUF, 4'h0}, {tx, 12'hfff});
        bus(1'b1, OFF_CTRL1, c1);
        s = frames;
        while (frames < s + 4) @(posedge clk);
        chk("sent bits", got, tx);
        chk("pin enables", {clock_pin_oe, serial_out_oe, frame_sync_pin_oe}, {~c1[10], 1'b1, ~c1[8]});
        bus(1'b0, OFF_STAT, 16'h0);
        chk("rx full", rd[ST_RFUL], 1'b1);
        chk("rx overflow", rd[ST_ROV], 1'b1);
        chk("tx underflow", {rd[ST_TUNF], rd[ST_TMPTY]}, 2'b11);
        rchk({AREA_RXBUF, 4'h0}, {rx_in, 12'h000}, "rx word");
        bus(1'b1, OFF_CTRL1, 16'h0);
        ext <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pin release", {clock_pin_oe, serial_out_oe, frame_sync_pin_oe}, 32'h0);
        // disabled block sets no flags, so the clears must stick
        bus(1'b1, OFF_STAT, 16'h000a);
        bus(1'b0, OFF_STAT, 16'h0);
        chk("flag clear", {rd[ST_ROV], rd[ST_TUNF], rd[ST_TMPTY]}, 3'b001);
    endtask
    // slot not enabled for transmit: float, then drive zeros
    task automatic idle_slots;
        logic bad;
        logic [15:0] c1 [2] = '{16'h82c0, 16'h8280};
        bus(1'b1, OFF_TXSLOT, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, OFF_CTRL1, c1[k]);
            repeat (100) @(posedge clk);
            bad = 1'b0;
            repeat (64) begin
                @(posedge clk);
                if ({serial_out_oe, serial_out_pin} !== (k == 0 ? 2'b00 : 2'b10)) bad = 1'b1;
            end
            chk("idle data out", bad, 1'b0);
        end
        bus(1'b1, OFF_CTRL1, 16'h0);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        regs_check;
        run_link(16'h8280, 4'ha, 4'hc);
        idle_slots;
        run_link(16'h8780, 4'h5, 4'h3);
        run_link(16'h8081, 4'h9, 4'h6);
        print_verdict;
    end
endmodule
